/* limit_mon_pkg.sv */
// Package: register map, field layout and types for the limit monitor block
`default_nettype none
package limit_mon_pkg;
  localparam int NUM_CH = 8;
  localparam logic [11:0] OFF_START_TASK = 12'h000;
  localparam logic [11:0] OFF_SAMPLE_TASK = 12'h004;
  localparam logic [11:0] OFF_STOP_TASK = 12'h008;
  localparam logic [11:0] OFF_CAL_TASK = 12'h00c;
  localparam logic [11:0] OFF_STARTED_EV = 12'h100;
  localparam logic [11:0] OFF_BUF_FULL_EV = 12'h104;
  localparam logic [11:0] OFF_CONV_DONE_EV = 12'h108;
  localparam logic [11:0] OFF_RES_READY_EV = 12'h10c;
  localparam logic [11:0] OFF_CAL_DONE_EV = 12'h110;
  localparam logic [11:0] OFF_STOPPED_EV = 12'h114;
  localparam logic [11:0] OFF_CH_EV_BASE = 12'h118;
  localparam logic [11:0] OFF_CH7_HIGH_EV = 12'h150;
  localparam logic [11:0] OFF_CH7_LOW_EV = 12'h154;
  localparam logic [11:0] OFF_INT_EN = 12'h300;
  localparam logic [11:0] OFF_INT_SET = 12'h304;
  localparam logic [11:0] OFF_INT_CLR = 12'h308;
  localparam logic [11:0] OFF_STATUS = 12'h400;
  localparam logic [11:0] OFF_ENABLE = 12'h500;
  localparam logic [11:0] OFF_LIMIT_BASE = 12'h51c;
  localparam logic [11:0] LIMIT_STRIDE = 12'h010;
  localparam int LIM_HIGH_LSB = 16;
  localparam int LIM_LOW_LSB = 0;
  localparam logic [31:0] LIMIT_RESET = 32'h7fff_8000;
  localparam int NUM_EV = 6 + 2 * NUM_CH;
  localparam int CAL_TIME_NS = 100;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  // Control sequencer states, Gray along the path
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_RUN = 2'b01,
    ST_CAL = 2'b11
  } seq_state_t;

  // One converter result handed in from the analog side
  typedef struct packed {
    logic valid;
    logic [2:0] ch;
    logic [15:0] value;
    logic last_conv;
    logic buf_full;
  } conv_result_t;
endpackage : limit_mon_pkg
`default_nettype wire

/* limit_store.sv */
// Small register file holding the per-channel limit words
`timescale 1ns/1ps
`default_nettype none
module limit_store
  import limit_mon_pkg::*;
#(
  parameter int DEPTH = NUM_CH
)
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RSTN,
  // Write port
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input wire logic [31:0] wr_data,
  // Registered read port
  input wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic [31:0] rd_data,
  // All words, for the comparators
  output logic [DEPTH-1:0][31:0] words
);
  if (DEPTH < 2) $error("limit_store needs at least two words");

  logic [DEPTH-1:0][31:0] mem_q;

  // Word storage
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      mem_q <= {DEPTH{LIMIT_RESET}};
    else if (wr_en)
      mem_q[wr_idx] <= wr_data;
  end

  // Registered read
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      rd_data <= 32'h0000_0000;
    else
      rd_data <= mem_q[rd_idx];
  end

  assign words = mem_q;
endmodule : limit_store
`default_nettype wire

/* limit_monitor.sv */
// Converter control: tasks, events, limit monitor, calibration, AHB-Lite slave
// Function
// [RULE1] Each channel holds upper and lower limit
// [RULE2] Software keeps upper not below lower
// [RULE3] Result outside band raises a monitoring event
// [RULE4] Swapped limits never give inside-band event
// [RULE5] Comparison always runs, no enable needed; here each comparator is gated by the ENABLE register (enable_q)
// [RULE6] Result at or above upper sets high
// [RULE7] Result at or below lower sets low
// [RULE8] Calibrate task starts calibration, completion event
// [RULE9] Software calibrates before use and on drift
// [RULE10] Start task starts converter, prepares buffer
// [RULE11] Sample task takes one sample
// [RULE12] Stop task stops converter, aborts conversions
// [RULE13] Started event after converter starts
// [RULE14] End event when buffer is full
// [RULE15] Conversion done event after each conversion
// [RULE16] Result ready event when result ready
// [RULE17] Interrupt enable bit per event source
// [RULE18] Enable register switches peripheral on/off
// [RULE19] Results are signed, sixteen bits wide
// [RULE20] Set/clear registers write one, zero ignored
// [RULE21] Event sticky until zero written; gated interrupt
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module limit_monitor
  import limit_mon_pkg::*;
#(
  parameter int CAL_COUNT = CAL_CYCLES
)
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RSTN,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Converter result stream
  input wire conv_result_t CONV_IN,
  // Converter controls
  output logic CONV_START,
  output logic CONV_SAMPLE,
  output logic CONV_ABORT,
  output logic CONV_POWER,
  output logic CAL_BUSY,
  // Interrupt request
  output logic IRQ
);
  if (CAL_COUNT < 1 || CAL_COUNT > 65535) $error("CAL_COUNT out of range");

  ////////////////////////////////////////////////////////////////////////////
  // Bus address phase capture
  logic wr_pend_q, rd_pend_q;
  logic [11:0] addr_q;
  wire logic take = HSEL & HREADY & (HTRANS == HTRANS_NONSEQ);

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 12'h000;
    end
    else
    begin
      wr_pend_q <= take & HWRITE;
      rd_pend_q <= take & ~HWRITE;
      if (take)
        addr_q <= HADDR[11:0];
    end
  end

  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  wire logic wr_start = wr_pend_q & hit(addr_q, OFF_START_TASK) & HWDATA[0];
  wire logic wr_sample = wr_pend_q & hit(addr_q, OFF_SAMPLE_TASK) & HWDATA[0];
  wire logic wr_stop = wr_pend_q & hit(addr_q, OFF_STOP_TASK) & HWDATA[0];
  wire logic wr_cal = wr_pend_q & hit(addr_q, OFF_CAL_TASK) & HWDATA[0];
  wire logic wr_interrupt_enable = wr_pend_q & hit(addr_q, OFF_INT_EN);
  wire logic wr_inset = wr_pend_q & hit(addr_q, OFF_INT_SET);
  wire logic wr_inclr = wr_pend_q & hit(addr_q, OFF_INT_CLR);
  wire logic wr_enable = wr_pend_q & hit(addr_q, OFF_ENABLE);
  wire logic [11:0] lim_rel = addr_q - OFF_LIMIT_BASE;
  wire logic lim_sel = (addr_q >= OFF_LIMIT_BASE) && (lim_rel[3:0] == 4'h0)
    && (lim_rel[11:4] < 8'(NUM_CH));
  wire logic [2:0] lim_idx = lim_rel[6:4];
  wire logic ev_sel = (addr_q >= OFF_STARTED_EV) && (addr_q <= OFF_CH7_LOW_EV)
    && (addr_q[1:0] == 2'b00);
  wire logic [11:0] ev_rel = addr_q - OFF_STARTED_EV;
  wire logic [4:0] ev_idx = ev_rel[6:2];

  ////////////////////////////////////////////////////////////////////////////
  // Enable register and sequencer
  logic enable_q;
  seq_state_t state_q, state_d;
  logic [15:0] cal_cnt_q;
  logic started_pulse, cal_done_pulse, stopped_pulse;

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      enable_q <= 1'b0;
    else if (wr_enable)
      enable_q <= HWDATA[0]; // RULE18
  end

  // Next-state selection
  always_comb
  begin
    state_d = state_q;
    if (!enable_q)
      state_d = ST_OFF;
    else
      unique case (state_q)
        ST_OFF:
          if (wr_cal)
            state_d = ST_CAL; // RULE8
          else if (wr_start)
            state_d = ST_RUN; // RULE10
        ST_RUN:
          if (wr_stop)
            state_d = ST_OFF; // RULE12
          else if (wr_cal)
            state_d = ST_CAL;
        ST_CAL:
          if (wr_stop || cal_cnt_q == 16'h0001)
            state_d = ST_OFF;
        default:
          state_d = ST_OFF;
      endcase
  end

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state_q <= ST_OFF;
      cal_cnt_q <= 16'h0000;
    end
    else
    begin
      state_q <= state_d;
      if (state_q != ST_CAL && state_d == ST_CAL)
        cal_cnt_q <= 16'(CAL_COUNT); // RULE8
      else if (cal_cnt_q != 16'h0000)
        cal_cnt_q <= cal_cnt_q - 16'h0001;
    end
  end

  assign started_pulse = enable_q & wr_start; // RULE13
  assign cal_done_pulse = (state_q == ST_CAL) & (cal_cnt_q == 16'h0001) & enable_q
    & ~wr_stop; // RULE8
  assign stopped_pulse = enable_q & wr_stop & (state_q != ST_OFF);

  // Converter control strobes
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      CONV_START <= 1'b0;
      CONV_SAMPLE <= 1'b0;
      CONV_ABORT <= 1'b0;
    end
    else
    begin
      CONV_START <= started_pulse; // RULE10
      CONV_SAMPLE <= wr_sample & enable_q & (state_q == ST_RUN); // RULE11
      CONV_ABORT <= wr_stop & enable_q; // RULE12
    end
  end

  assign CONV_POWER = enable_q;
  assign CAL_BUSY = (state_q == ST_CAL);

  ////////////////////////////////////////////////////////////////////////////
  // Limit storage and comparators
  logic [NUM_CH-1:0][31:0] lim_words;
  logic [31:0] lim_rd;
  logic [NUM_CH-1:0] above_hit, below_hit;

  limit_store #(.DEPTH(NUM_CH)) u_store (
    .MCLK(MCLK),
    .RSTN(RSTN),
    .wr_en(wr_pend_q & lim_sel), // RULE1
    .wr_idx(lim_idx),
    .wr_data(HWDATA),
    .rd_idx(HADDR[6:4] - 3'h1),
    .rd_data(lim_rd),
    .words(lim_words)
  );

  // Signed compare of the incoming result against each channel's band
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_cmp
    wire logic signed [15:0] hi = lim_words[c][LIM_HIGH_LSB +: 16];
    wire logic signed [15:0] lo = lim_words[c][LIM_LOW_LSB +: 16];
    wire logic signed [15:0] res = CONV_IN.value; // RULE19
    wire logic mine = CONV_IN.valid & enable_q & (CONV_IN.ch == 3'(c));
    // Each test on its own limit, so swapped limits cannot form an inside band
    assign above_hit[c] = mine & (res >= hi); // RULE6 RULE3 RULE4 RULE5
    assign below_hit[c] = mine & (res <= lo); // RULE7 RULE3 RULE4 RULE5
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky event flags, index = (offset - 0x100) / 4
  logic [NUM_EV-1:0] ev_q, ev_set, interrupt_enable_q;
  wire logic conv_ok = CONV_IN.valid & enable_q & (state_q == ST_RUN);

  always_comb
  begin
    ev_set = '0;
    ev_set[0] = started_pulse;
    ev_set[1] = conv_ok & CONV_IN.buf_full; // RULE14
    ev_set[2] = conv_ok; // RULE15
    ev_set[3] = conv_ok & CONV_IN.last_conv; // RULE16
    ev_set[4] = cal_done_pulse;
    ev_set[5] = stopped_pulse;
    for (int c = 0; c < NUM_CH; c++)
    begin
      ev_set[6 + 2 * c] = above_hit[c];
      ev_set[7 + 2 * c] = below_hit[c];
    end
  end

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      ev_q <= '0;
    else
      for (int e = 0; e < NUM_EV; e++)
        if (ev_set[e])
          ev_q[e] <= 1'b1; // RULE21
        else if (wr_pend_q && ev_sel && ev_idx == 5'(e) && !HWDATA[0])
          ev_q[e] <= 1'b0; // RULE21
  end

  // Interrupt enable with set/clear aliases
  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
      interrupt_enable_q <= '0;
    else if (wr_interrupt_enable)
      interrupt_enable_q <= HWDATA[NUM_EV-1:0]; // RULE17
    else if (wr_inset)
      interrupt_enable_q <= interrupt_enable_q | HWDATA[NUM_EV-1:0]; // RULE20
    else if (wr_inclr)
      interrupt_enable_q <= interrupt_enable_q & ~HWDATA[NUM_EV-1:0]; // RULE20
  end

  assign IRQ = |(ev_q & interrupt_enable_q); // RULE21

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered from the address phase
  logic [11:0] raddr;
  logic [31:0] rd_mux;
  logic lim_rd_q;
  logic [31:0] hrdata_q;
  assign raddr = HADDR[11:0];
  wire logic [11:0] rev_rel = raddr - OFF_STARTED_EV;
  wire logic rev_sel = (raddr >= OFF_STARTED_EV) && (raddr <= OFF_CH7_LOW_EV)
    && (raddr[1:0] == 2'b00);
  wire logic [11:0] rlim_rel = raddr - OFF_LIMIT_BASE;
  wire logic rlim_sel = (raddr >= OFF_LIMIT_BASE) && (rlim_rel[3:0] == 4'h0)
    && (rlim_rel[11:4] < 8'(NUM_CH));

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (rev_sel)
      rd_mux = {31'h0, ev_q[rev_rel[6:2]]};
    else if (raddr == OFF_INT_EN || raddr == OFF_INT_SET || raddr == OFF_INT_CLR)
      rd_mux = {{(32-NUM_EV){1'b0}}, interrupt_enable_q};
    else if (raddr == OFF_STATUS)
      rd_mux = {31'h0, state_q != ST_OFF};
    else if (raddr == OFF_ENABLE)
      rd_mux = {31'h0, enable_q};
  end

  always_ff @(posedge MCLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      hrdata_q <= 32'h0000_0000;
      lim_rd_q <= 1'b0;
    end
    else
    begin
      lim_rd_q <= take & ~HWRITE & rlim_sel;
      if (take && !HWRITE)
        hrdata_q <= rd_mux;
    end
  end

  // Limit words come from the store's own registered port
  assign HRDATA = lim_rd_q ? lim_rd : hrdata_q; // RULE1

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_HIGH_EVT: assert property (@(posedge MCLK) disable iff (!RSTN) // RULE6
    above_hit[7] |=> ev_q[20])
    else $error("above-high flag not set");
  AST_LOW_EVT: assert property (@(posedge MCLK) disable iff (!RSTN) // RULE7
    below_hit[0] |=> ev_q[7])
    else $error("below-low flag not set");
  AST_STICKY: assert property (@(posedge MCLK) disable iff (!RSTN) // RULE21
    ev_q[2] && !(wr_pend_q && ev_sel && ev_idx == 5'd2) |=> ev_q[2])
    else $error("event flag dropped without write");
  AST_IRQ: assert property (@(posedge MCLK) disable iff (!RSTN) // RULE21
    (ev_q[4] && interrupt_enable_q[4]) |-> IRQ)
    else $error("interrupt missing");
  AST_CAL: assert property (@(posedge MCLK) disable iff (!RSTN) // RULE8
    (state_q == ST_OFF && enable_q && wr_cal && !wr_enable) |=> CAL_BUSY)
    else $error("calibration did not start");
  AST_STOP: assert property (@(posedge MCLK) disable iff (!RSTN) // RULE12
    (enable_q && wr_stop) |=> CONV_ABORT ##0 (state_q == ST_OFF))
    else $error("stop did not abort");
  AST_START: assert property (@(posedge MCLK) disable iff (!RSTN) // RULE13
    started_pulse |=> ev_q[0] && CONV_START)
    else $error("started event missing");
  AST_SETCLR: assert property (@(posedge MCLK) disable iff (!RSTN) // RULE20
    (wr_inset && HWDATA[0]) |=> interrupt_enable_q[0])
    else $error("interrupt set ignored");
  AST_OFF: assert property (@(posedge MCLK) disable iff (!RSTN) // RULE18
    !enable_q |=> state_q == ST_OFF)
    else $error("sequencer ran while disabled");
  AST_DONE: assert property (@(posedge MCLK) disable iff (!RSTN) // RULE15
    conv_ok |=> ev_q[2])
    else $error("conversion done not flagged");
endmodule : limit_monitor
`default_nettype wire

/* limit_monitor_tb_top.sv */
// Self-checking bench for the converter limit monitor block
`timescale 1ns/1ps
`default_nettype none
module limit_monitor_tb_top
  import limit_mon_pkg::*;
();
  localparam int CAL_SIM = 3;
  logic MCLK = 1'b0, RSTN = 1'b0, HSEL = 1'b0, HWRITE = 1'b0;
  logic [31:0] HADDR = '0, HWDATA = '0, HRDATA, d;
  logic [1:0] HTRANS = 2'b00;
  logic [2:0] HSIZE = 3'h2, c;
  logic HREADY, HREADYOUT, HRESP, CONV_START, CONV_SAMPLE, CONV_ABORT, CONV_POWER;
  logic CAL_BUSY, IRQ;
  logic [15:0] a, b, v;
  logic [15:0] lim_hi [NUM_CH];
  logic [15:0] lim_lo [NUM_CH];
  conv_result_t CONV_IN = '0;
  int err_count = 0, check_count = 0, cyc = 0, n_start = 0, n_sample = 0, n_abort = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, single-slave ready loop, design
  always #5 MCLK = ~MCLK;
  assign HREADY = HREADYOUT;

  limit_monitor #(.CAL_COUNT(CAL_SIM)) DUT (
    .MCLK(MCLK), .RSTN(RSTN), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CONV_IN(CONV_IN), .CONV_START(CONV_START),
    .CONV_SAMPLE(CONV_SAMPLE), .CONV_ABORT(CONV_ABORT), .CONV_POWER(CONV_POWER),
    .CAL_BUSY(CAL_BUSY), .IRQ(IRQ)
  );

  // Pulse counters and hang guard
  always @(posedge MCLK)
  begin
    cyc <= cyc + 1;
    n_start <= n_start + int'(CONV_START === 1'b1);
    n_sample <= n_sample + int'(CONV_SAMPLE === 1'b1);
    n_abort <= n_abort + int'(CONV_ABORT === 1'b1);
    if (cyc == 20000)
    begin
      err_count++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and comparison
  task automatic test_done();
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  // Expected above-high and below-low flags, signed compare
  function automatic logic [1:0] lim_exp(input logic [2:0] ch, input logic [15:0] val);
    return {$signed(val) >= $signed(lim_hi[ch]), $signed(val) <= $signed(lim_lo[ch])};
  endfunction : lim_exp

  ////////////////////////////////////////////////////////////////////////////////
  // Bus master: hold address until ready, then data phase until ready
  task automatic ahb_wr(input logic [11:0] ad, input logic [31:0] wd);
    HSEL <= 1'b1;
    HADDR <= {20'h0, ad};
    HTRANS <= HTRANS_NONSEQ;
    HWRITE <= 1'b1;
    do @(posedge MCLK); while (HREADY !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= wd;
    do @(posedge MCLK); while (HREADY !== 1'b1);
    @(posedge MCLK);
    #1;
  endtask : ahb_wr

  task automatic rc(input logic [11:0] ad, input logic [31:0] e);
    HSEL <= 1'b1;
    HADDR <= {20'h0, ad};
    HTRANS <= HTRANS_NONSEQ;
    HWRITE <= 1'b0;
    do @(posedge MCLK); while (HREADY !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    do @(posedge MCLK); while (HREADY !== 1'b1);
    d = HRDATA;
    chk(d, e);
  endtask : rc

  // One converter result pulse
  task automatic send(input logic [2:0] ch, input logic [15:0] val, input logic l,
                      input logic f);
    @(posedge MCLK);
    CONV_IN <= '{valid: 1'b1, ch: ch, value: val, last_conv: l, buf_full: f};
    @(posedge MCLK);
    CONV_IN.valid <= 1'b0;
    repeat (2) @(posedge MCLK);
    #1;
  endtask : send

  // Send a result, check and clear its events
  task automatic mon(input logic [2:0] ch, input logic [15:0] val, input logic run);
    logic l, f;
    logic [1:0] e;
    logic [11:0] ea;
    l = 1'($urandom);
    f = 1'($urandom);
    e = lim_exp(ch, val);
    ea = OFF_CH_EV_BASE + {6'h0, ch, 3'h0};
    send(ch, val, l, f);
    rc(ea, {31'h0, e[1]});
    rc(ea + 12'h4, {31'h0, e[0]});
    rc(OFF_CONV_DONE_EV, {31'h0, run});
    rc(OFF_RES_READY_EV, {31'h0, run & l});
    rc(OFF_BUF_FULL_EV, {31'h0, run & f});
    ahb_wr(ea, 32'h0);
    ahb_wr(ea + 12'h4, 32'h0);
    ahb_wr(OFF_CONV_DONE_EV, 32'h0);
    ahb_wr(OFF_RES_READY_EV, 32'h0);
    ahb_wr(OFF_BUF_FULL_EV, 32'h0);
    rc(ea, 32'h0);
    rc(OFF_CONV_DONE_EV, 32'h0);
  endtask : mon

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    void'($urandom(96796));
    for (int i = 0; i < NUM_CH; i++)
    begin
      lim_hi[i] = 16'h7fff;
      lim_lo[i] = 16'h8000;
    end
    repeat (2) @(posedge MCLK);
    RSTN <= 1'b1;
    @(posedge MCLK);
    #1;
    rc(OFF_STATUS, 32'h0);
    rc(OFF_ENABLE, 32'h0);
    rc(OFF_INT_EN, 32'h0);
    rc(OFF_STARTED_EV, 32'h0);
    rc(12'h600, 32'h0);
    chk({31'h0, HRESP}, 32'h0);
    ahb_wr(OFF_START_TASK, 32'h1);
    chk(n_start, 0);
    ahb_wr(OFF_ENABLE, 32'h1);
    chk({31'h0, CONV_POWER}, 32'h1);
    // Calibrate before first use
    ahb_wr(OFF_CAL_TASK, 32'h1);
    chk({31'h0, CAL_BUSY}, 32'h1);
    for (int i = 0; i < 20 && CAL_BUSY === 1'b1; i++) @(posedge MCLK);
    @(posedge MCLK);
    #1;
    chk({31'h0, CAL_BUSY}, 32'h0);
    rc(OFF_CAL_DONE_EV, 32'h1);
    rc(OFF_STATUS, 32'h0);
    ahb_wr(OFF_SAMPLE_TASK, 32'h1);
    chk(n_sample, 0);
    ahb_wr(OFF_START_TASK, 32'h1);
    chk(n_start, 1);
    rc(OFF_STARTED_EV, 32'h1);
    rc(OFF_STATUS, 32'h1);
    ahb_wr(OFF_SAMPLE_TASK, 32'h1);
    chk(n_sample, 1);
    // Interrupt enable, set, clear and gating
    chk({31'h0, IRQ}, 32'h0);
    ahb_wr(OFF_INT_SET, 32'h1);
    chk({31'h0, IRQ}, 32'h1);
    ahb_wr(OFF_INT_CLR, 32'h0);
    rc(OFF_INT_EN, 32'h1);
    ahb_wr(OFF_STARTED_EV, 32'h0);
    chk({31'h0, IRQ}, 32'h0);
    ahb_wr(OFF_INT_CLR, 32'h1);
    rc(OFF_INT_EN, 32'h0);
    // Calibration-done flag is still set: enable its interrupt, then clear it
    ahb_wr(OFF_INT_EN, 32'h10);
    chk({31'h0, IRQ}, 32'h1);
    ahb_wr(OFF_CAL_DONE_EV, 32'h0);
    chk({31'h0, IRQ}, 32'h0);
    ahb_wr(OFF_INT_EN, 32'h4);
    rc(OFF_INT_EN, 32'h4);
    send(3'd0, 16'h0000, 1'b0, 1'b0);
    chk({31'h0, IRQ}, 32'h1);
    ahb_wr(OFF_CONV_DONE_EV, 32'h0);
    chk({31'h0, IRQ}, 32'h0);
    ahb_wr(OFF_INT_EN, 32'h0);
    // Reset limits at their extremes, then random limits
    mon(3'd7, 16'h7fff, 1'b1);
    mon(3'd0, 16'h8000, 1'b1);
    mon(3'd0, 16'h0000, 1'b1);
    for (int i = 0; i < 24; i++)
    begin
      c = 3'($urandom);
      a = 16'($urandom);
      b = 16'($urandom);
      if (i % 4 != 3 && $signed(a) < $signed(b)) {a, b} = {b, a};
      lim_hi[c] = a;
      lim_lo[c] = b;
      ahb_wr(OFF_LIMIT_BASE + LIMIT_STRIDE * {9'h0, c}, {a, b});
      rc(OFF_LIMIT_BASE + LIMIT_STRIDE * {9'h0, c}, {a, b});
      case (i % 3)
        0: v = a;
        1: v = b;
        default: v = 16'($urandom);
      endcase
      mon(c, v, 1'b1);
    end
    // Stop, then comparison keeps running while idle
    ahb_wr(OFF_STOP_TASK, 32'h1);
    chk(n_abort, 1);
    rc(OFF_STOPPED_EV, 32'h1);
    rc(OFF_STATUS, 32'h0);
    ahb_wr(OFF_SAMPLE_TASK, 32'h1);
    chk(n_sample, 1);
    mon(3'd2, lim_lo[2], 1'b0);
    ahb_wr(OFF_ENABLE, 32'h0);
    chk({31'h0, CONV_POWER}, 32'h0);
    test_done();
  end
endmodule : limit_monitor_tb_top
`default_nettype wire
